//--- core/adc_sequencer.v
// Purpose : phase sequencer and serial result port for a dual-slope converter
// Assumes : osc_input, zero_cross_in, convert_en_n, load_n, read_n, serial_in and
//           serial_shift_clock are asynchronous and pass two flip-flops first
// Notes   : osc_input is sampled by sys_clk; its rising edges make timebase ticks
//
// Summary of operation
// - divide oscillator by four for timebase
// - step phases: auto-zero, integrate, de-integrate, zero
// - sixteen-bit counter, preset high, low byte ff
// - preset ff..00 gives 256..65536 counts
// - de-integrate until comparator changes state
// - count de-integrate periods as the result
// - integrator-zero until comparator high, then restart
// - sample serial input on shift clock rise
// - shift result bit out on clock fall
// - read line high ends read, floats output
// - overrange first, then polarity, count msb first
// - power-up in integrator-zero, await comparator high
// - new result readable from integrator-zero start
// - result readable at any time
// - valid low during auto-zero, high after
// - convert-enable high holds auto-zero
// - shift preset byte msb first, latch on rise
// - bare load pulse selects 65536 or 32768
`include "adc_seq_defines.vh"
module adc_sequencer #(
    parameter CNT_W = 16
) (
    input  wire       sys_clk,            // system clock, 250 MHz
    input  wire       sys_rst,            // synchronous reset, active high
    input  wire       osc_input,          // oscillator input
    output reg        osc_output,         // divided timebase monitor
    input  wire       zero_cross_in,      // converter comparator
    input  wire       convert_en_n,       // convert enable, active low
    input  wire       load_n,             // preset load, active low
    input  wire       read_n,             // read enable, active low
    input  wire       serial_shift_clock, // serial port clock
    input  wire       serial_in,          // serial data in
    output reg        serial_out,         // serial data out
    output reg        serial_out_oe,      // serial out driven
    output reg  [1:0] phase_sel,          // phase select a,b
    output reg        result_valid_n,     // data valid, active low
    output reg        result_overflow     // a result was dropped
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [1:0] s_osc, s_cmp, s_ce, s_ld, s_rd, s_sck, s_din;
    always @(posedge sys_clk) begin
        s_osc <= {s_osc[0], osc_input};
        s_cmp <= {s_cmp[0], zero_cross_in};
        s_ce  <= {s_ce[0],  convert_en_n};
        s_ld  <= {s_ld[0],  load_n};
        s_rd  <= {s_rd[0],  read_n};
        s_sck <= {s_sck[0], serial_shift_clock};
        s_din <= {s_din[0], serial_in};
    end
    wire osc_s = s_osc[1];
    wire sck_s = s_sck[1];
    wire ld_s  = s_ld[1];
    wire rd_s  = s_rd[1];
    wire din_s = s_din[1];

    // ------------------------------------------------------------
    // timebase: osc divided by four
    // ------------------------------------------------------------
    reg       osc_d;
    reg [2:0] div_cnt;
    reg       tick;
    always @(posedge sys_clk) begin
        osc_d <= osc_s;
        tick  <= 1'b0;
        if (sys_rst) begin
            div_cnt    <= 3'h0;
            osc_output <= 1'b0;
        end else if (osc_s && !osc_d) begin
            if (div_cnt == `TB_DIVIDE - 3'h1) begin
                div_cnt <= 3'h0;
                tick    <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 3'h1;
            end
            osc_output <= (div_cnt < 3'h2) ? 1'b1 : 1'b0;
        end
    end

    // inputs used by the phase machine, resampled on the timebase tick
    reg cmp_t, ce_t, ld_t;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cmp_t <= 1'b0;
            ce_t  <= 1'b0;
            ld_t  <= 1'b1;
        end else if (tick) begin
            cmp_t <= s_cmp[1];
            ce_t  <= s_ce[1];
            ld_t  <= ld_s;
        end
    end

    // ------------------------------------------------------------
    // preset loading
    // ------------------------------------------------------------
    reg       sck_d, ld_d;
    reg [7:0] preset_sr;
    reg [3:0] preset_bits;
    reg [7:0] preset;
    wire      sck_rise = sck_s && !sck_d;
    wire      sck_fall = !sck_s && sck_d;
    always @(posedge sys_clk) begin
        sck_d <= sck_s;
        ld_d  <= ld_s;
        if (sys_rst) begin
            preset      <= `PRESET_RESET;
            preset_bits <= 4'h0;
            preset_sr   <= 8'h00;
        end else begin
            if (!ld_s && ld_d)
                preset_bits <= 4'h0;
            else if (!ld_s && sck_rise) begin
                preset_sr <= {preset_sr[6:0], din_s};
                if (preset_bits != 4'h8)
                    preset_bits <= preset_bits + 4'h1;
            end
            if (ld_s && !ld_d) begin
                if (preset_bits == 4'h0)
                    preset <= din_s ? `PRESET_PULSE_HI : `PRESET_PULSE_LO;
                else
                    preset <= preset_sr;
            end
        end
    end

    // ------------------------------------------------------------
    // phase machine
    // ------------------------------------------------------------
    reg [1:0]        phase;
    reg [CNT_W-1:0]  tb_cnt;
    reg [CNT_W-1:0]  deintegrate_phase_cnt;
    reg              cmp_start;
    reg              ovr;
    reg              res_valid;
    reg [17:0]       res_word;

    // next values of the phase machine
    reg [1:0]        next_phase;
    reg [CNT_W-1:0]  next_tb_cnt;
    reg [CNT_W-1:0]  next_deintegrate_phase_cnt;
    reg              next_cmp_start;
    reg              next_ovr;
    reg              next_res_valid;
    reg [17:0]       next_res_word;
    wire             buf_ready;
    wire [CNT_W-1:0] tb_last  = {CNT_W{1'b1}};
    wire [CNT_W-1:0] tb_one   = {{(CNT_W-1){1'b0}}, 1'b1};
    // down-counter: complement of preset over the fixed low byte, zero ends the phase
    wire [CNT_W-1:0] tb_load  = {~preset, `COUNT_LOW_BYTE};
    wire             tb_done  = (tb_cnt == {CNT_W{1'b0}});
    wire             force_az = ce_t || !ld_t;

    // phase decode, acted on only when a timebase tick arrives
    always @* begin
        next_phase     = phase;
        next_tb_cnt    = tb_cnt;
        next_deintegrate_phase_cnt  = deintegrate_phase_cnt;
        next_cmp_start = cmp_start;
        next_ovr       = ovr;
        next_res_valid = 1'b0;
        next_res_word  = res_word;
        case (phase)
            `PHASE_IZ: begin
                if (force_az) begin
                    next_phase  = `PHASE_AZ;
                    next_tb_cnt = tb_load;
                end else if (cmp_t) begin
                    next_phase  = `PHASE_AZ;
                    next_tb_cnt = tb_load;
                end
            end
            `PHASE_AZ: begin
                if (force_az) begin
                    next_tb_cnt = tb_load;
                end else if (tb_done) begin
                    next_phase  = `PHASE_INT;
                    next_tb_cnt = tb_load;
                end else begin
                    next_tb_cnt = tb_cnt - tb_one;
                end
            end
            `PHASE_INT: begin
                if (tb_done) begin
                    next_phase     = `PHASE_DEINTEGRATE_PHASE;
                    next_deintegrate_phase_cnt  = {CNT_W{1'b0}};
                    next_cmp_start = cmp_t;
                    next_ovr       = 1'b0;
                end else begin
                    next_tb_cnt = tb_cnt - tb_one;
                end
            end
            `PHASE_DEINTEGRATE_PHASE: begin
                if (cmp_t != cmp_start) begin
                    next_phase     = `PHASE_IZ;
                    next_res_word  = {ovr, cmp_start, deintegrate_phase_cnt};
                    next_res_valid = 1'b1;
                end else if (deintegrate_phase_cnt == tb_last) begin
                    next_ovr = 1'b1;
                end else begin
                    next_deintegrate_phase_cnt = deintegrate_phase_cnt + tb_one;
                end
            end
            default: begin
                next_phase = `PHASE_IZ;
            end
        endcase
    end

    // phase registers step once per tick; the result strobe lasts one clock
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            phase     <= `PHASE_IZ;
            tb_cnt    <= {CNT_W{1'b0}};
            deintegrate_phase_cnt  <= {CNT_W{1'b0}};
            cmp_start <= 1'b0;
            ovr       <= 1'b0;
            res_valid <= 1'b0;
            res_word  <= 18'h00000;
        end else begin
            res_valid <= tick && next_res_valid;
            if (tick) begin
                phase     <= next_phase;
                tb_cnt    <= next_tb_cnt;
                deintegrate_phase_cnt  <= next_deintegrate_phase_cnt;
                cmp_start <= next_cmp_start;
                ovr       <= next_ovr;
                res_word  <= next_res_word;
            end
        end
    end

    // ------------------------------------------------------------
    // result buffer and serial readout
    // ------------------------------------------------------------
    wire [17:0] buf_data;
    wire        buf_valid;
    reg         take;
    word_buffer #(
        .WIDTH     (18)
    ) u_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_data   (res_word),
        .in_valid  (res_valid),
        .in_ready  (buf_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (take)
    );

    reg [17:0] latest;
    reg [17:0] shifter;
    reg        rd_d;
    always @(posedge sys_clk) begin
        rd_d <= rd_s;
        if (sys_rst) begin
            latest          <= 18'h00000;
            shifter         <= 18'h00000;
            take            <= 1'b0;
            serial_out      <= 1'b0;
            serial_out_oe   <= 1'b0;
            phase_sel       <= `PHASE_IZ;
            result_valid_n  <= 1'b1;
            result_overflow <= 1'b0;
        end else begin
            phase_sel      <= phase;
            result_valid_n <= (phase == `PHASE_AZ) ? 1'b0 : 1'b1;
            if (res_valid && !buf_ready)
                result_overflow <= 1'b1;
            // keep the newest result; stall while a read is active
            take <= buf_valid && !take && rd_s;
            if (take)
                latest <= buf_data;
            if (rd_s) begin
                serial_out_oe <= 1'b0;
                shifter       <= take ? buf_data : latest;
            end else begin
                serial_out_oe <= 1'b1;
                if (rd_d) begin
                    serial_out <= shifter[17];
                    shifter    <= {shifter[16:0], 1'b0};
                end else if (sck_fall) begin
                    serial_out <= shifter[17];
                    shifter    <= {shifter[16:0], 1'b0};
                end
            end
        end
    end
endmodule

//--- core/adc_seq_defines.vh
// Purpose : constants for the dual-slope converter sequencer
// Assumes : included by its bare name
// Notes   : phase codes drive the two phase-select outputs
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define TB_DIVIDE          3'h4
`define PHASE_IZ           2'h0
`define PHASE_AZ           2'h1
`define PHASE_INT          2'h2
`define PHASE_DEINTEGRATE_PHASE         2'h3
`define COUNT_LOW_BYTE     8'hff
`define PRESET_RESET       8'h00
`define PRESET_PULSE_HI    8'h00
`define PRESET_PULSE_LO    8'h80
`define RESULT_BITS        5'h12
`endif

//--- core/word_buffer.v
// Purpose : two-entry valid/ready buffer for finished results
// Assumes : single clock, synchronous active-high reset
// Notes   : out side may stall; in_ready drops when both entries hold data
module word_buffer #(
    parameter WIDTH = 18
) (
    input  wire             sys_clk,   // clock
    input  wire             sys_rst,   // reset
    input  wire [WIDTH-1:0] in_data,   // word in
    input  wire             in_valid,  // word offered
    output wire             in_ready,  // room available
    output wire [WIDTH-1:0] out_data,  // oldest word
    output wire             out_valid, // word available
    input  wire             out_ready  // consumer takes
);
    reg [WIDTH-1:0] mem [0:1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       fill;
    wire            do_wr = in_valid && (fill != 2'h2);
    wire            do_rd = out_ready && (fill != 2'h0);

    assign in_ready  = (fill != 2'h2);
    assign out_valid = (fill != 2'h0);
    assign out_data  = mem[rd_ptr];

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill   <= 2'h0;
        end else begin
            if (do_wr) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (do_rd)
                rd_ptr <= ~rd_ptr;
            if (do_wr && !do_rd)
                fill <= fill + 2'h1;
            else if (do_rd && !do_wr)
                fill <= fill - 2'h1;
        end
    end
endmodule

//--- bench/adc_seq_sva.sv
// Purpose : port properties of the converter sequencer
// Assumes : timebase tick of 16 sys_clk cycles, preset ff
// Notes   : bound to adc_sequencer from the test file
module adc_seq_sva (
    input wire       sys_clk,       // clock
    input wire       sys_rst,       // reset
    input wire       osc_output,    // timebase monitor
    input wire       zero_cross_in, // comparator
    input wire       convert_en_n,  // convert enable
    input wire       load_n,        // preset load
    input wire       read_n,        // read enable
    input wire       serial_out_oe, // output enable
    input wire [1:0] phase_sel,     // phase code
    input wire       result_valid_n // data valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]  quiet;
    logic [5:0]  forced;
    logic [23:0] seg;
    logic [1:0]  prev;
    // cycles without force, and with comparator low
    always @(posedge sys_clk) begin
        if (sys_rst || zero_cross_in || convert_en_n || !load_n)
            quiet <= 6'h00;
        else if (quiet != 6'h3f)
            quiet <= quiet + 6'h01;
    end
    always @(posedge sys_clk) begin
        if (sys_rst || !(convert_en_n || !load_n))
            forced <= 6'h00;
        else if (forced != 6'h3f)
            forced <= forced + 6'h01;
    end
    // length of the current phase in cycles
    always @(posedge sys_clk) begin
        prev <= phase_sel;
        if (sys_rst || phase_sel != prev)
            seg <= 24'h000001;
        else
            seg <= seg + 24'h000001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_read_held;
        !read_n [*6];
    endsequence
    sequence s_osc_half;
        $stable(osc_output) [*6] ##[1:4] $changed(osc_output);
    endsequence
    a_valid_in_az: assert property (
        result_valid_n == (phase_sel != 2'h1)) else $error("valid flag disagrees with phase");
    a_osc_divide: assert property (
        $changed(osc_output) |=> s_osc_half) else $error("timebase half period wrong");
    a_phase_order: assert property (
        $changed(phase_sel) |-> phase_sel == $past(phase_sel) + 2'h1 || phase_sel == 2'h1)
        else $error("phase stepped out of order");
    a_force_az: assert property (
        forced == 6'h3f |-> phase_sel == 2'h1) else $error("forced but not in auto-zero");
    a_iz_wait: assert property (
        phase_sel == 2'h0 && quiet == 6'h3f |=> phase_sel == 2'h0) else $error("left zero phase early");
    a_az_length: assert property (
        phase_sel == 2'h2 && $past(phase_sel) == 2'h1 |-> seg >= 24'h000ffa) else $error("auto-zero short");
    a_int_length: assert property (
        phase_sel == 2'h3 && $past(phase_sel) == 2'h2 |-> seg >= 24'h000ffa) else $error("integrate short");
    a_read_drive: assert property (
        s_read_held |-> serial_out_oe) else $error("output not driven in read");
    a_idle_float: assert property (
        read_n [*6] |-> !serial_out_oe) else $error("output driven outside read");
endmodule

//--- bench/adc_host_model.sv
// Purpose : host side of the three-wire serial port
// Assumes : shift clock stands low between frames
// Notes   : tasks are called from the test module
module adc_host_model (
    input  wire  sys_clk,            // bench clock
    output logic load_n,             // preset load
    output logic read_n,             // read enable
    output logic serial_shift_clock, // 80 ns frame clock
    output logic serial_in,          // data to device
    input  wire  serial_out,         // data from device
    input  wire  serial_out_oe       // device drives data
);
    timeunit 1ns;
    timeprecision 1ps;
    wire dout = serial_out_oe ? serial_out : 1'bz;
    initial begin
        load_n = 1'b1;
        read_n = 1'b1;
        serial_shift_clock = 1'b0;
        serial_in = 1'b0;
    end
    task automatic half();
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic load(input logic [7:0] v);
        load_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            serial_in <= v[i];
            half();
            serial_shift_clock <= 1'b1;
            half();
            serial_shift_clock <= 1'b0;
        end
        half();
        load_n <= 1'b1;
        serial_in <= ~v[0];
        half();
    endtask
    task automatic pulse(input logic v);
        load_n    <= 1'b0;
        serial_in <= v;
        half();
        half();
        load_n    <= 1'b1;
        half();
    endtask
    task automatic read(output logic [17:0] w, output logic oe);
        read_n <= 1'b0;
        oe = 1'b1;
        for (int i = 17; i >= 0; i--) begin
            half();
            serial_shift_clock <= 1'b1;
            w[i] = dout;
            oe = oe & serial_out_oe;
            half();
            serial_shift_clock <= 1'b0;
        end
        read_n <= 1'b1;
        half();
    endtask
endmodule

//--- bench/adc_sequencer_test.sv
// Purpose : self-checking bench of the converter sequencer
// Assumes : oscillator of four sys_clk cycles, tick of 16
// Notes   : the converter comparator is driven here
module adc_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk, sys_rst, osc_input, zero_cross_in, convert_en_n;
    wire        load_n, read_n, serial_shift_clock, serial_in, serial_out;
    wire        serial_out_oe, osc_output, result_valid_n, result_overflow;
    wire  [1:0] phase_sel;
    int         num_errors, checks_done;
    adc_sequencer uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .osc_input(osc_input),
        .osc_output(osc_output), .zero_cross_in(zero_cross_in), .convert_en_n(convert_en_n),
        .load_n(load_n), .read_n(read_n), .serial_shift_clock(serial_shift_clock),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .phase_sel(phase_sel), .result_valid_n(result_valid_n), .result_overflow(result_overflow));
    adc_host_model host (.sys_clk(sys_clk), .load_n(load_n), .read_n(read_n),
        .serial_shift_clock(serial_shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        osc_input = 1'b0;
        forever begin
            repeat (2) @(posedge sys_clk);
            osc_input <= ~osc_input;
        end
    end
    task automatic check(input string s, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic near(input string s, input logic [23:0] lo, input logic [23:0] hi, input logic [23:0] g);
        checks_done++;
        if ($isunknown(g) || !(g >= lo && g <= hi)) begin
            num_errors++;
            $display("mismatch %s expected %h..%h seen %h", s, lo, hi, g);
        end
    endtask
    task automatic wait_phase(input logic [1:0] p, output logic [23:0] n);
        n = 24'h000000;
        while (phase_sel !== p && n < 24'h00ffff) begin
            @(posedge sys_clk);
            n = n + 24'h000001;
        end
        check("phase_sel", 24'(p), 24'(phase_sel));
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        repeat (1600) @(posedge sys_clk);
        check("phase_sel", 24'h000000, 24'(phase_sel));
        check("result_valid_n", 24'h000001, 24'(result_valid_n));
        check("serial_out_oe", 24'h000000, 24'(serial_out_oe));
    endtask
    task automatic t_force_load();
        convert_en_n <= 1'b1;
        host.load(8'hff);
        repeat (40) @(posedge sys_clk);
        check("phase_sel", 24'h000001, 24'(phase_sel));
        check("result_valid_n", 24'h000000, 24'(result_valid_n));
    endtask
    task automatic t_bare_pulse();
        host.pulse(1'b0);
        repeat (40) @(posedge sys_clk);
        convert_en_n <= 1'b0;
        repeat (6000) @(posedge sys_clk);
        check("phase_sel", 24'h000001, 24'(phase_sel));
        convert_en_n <= 1'b1;
        host.load(8'hff);
    endtask
    task automatic t_convert(input logic pol, input logic [23:0] ticks);
        logic [23:0] n;
        zero_cross_in <= pol;
        convert_en_n <= 1'b1;
        repeat (40) @(posedge sys_clk);
        convert_en_n <= 1'b0;
        wait_phase(2'h1, n);
        wait_phase(2'h2, n);
        near("az_cycles", 24'h000ff0, 24'h001022, n);
        wait_phase(2'h3, n);
        near("int_cycles", 24'h000ff0, 24'h001010, n);
        repeat (16 * ticks) @(posedge sys_clk);
        check("phase_sel", 24'h000003, 24'(phase_sel));
        zero_cross_in <= ~pol;
        wait_phase(2'h0, n);
        near("deintegrate_phase_exit", 24'h000000, 24'h000028, n);
        if (pol) begin
            repeat (1600) @(posedge sys_clk);
            check("phase_sel", 24'h000000, 24'(phase_sel));
            zero_cross_in <= 1'b1;
        end
        wait_phase(2'h1, n);
        near("iz_exit", 24'h000000, 24'h000028, n);
        check("result_valid_n", 24'h000000, 24'(result_valid_n));
    endtask
    task automatic t_read(input logic pol, input logic [23:0] ticks);
        logic [17:0] w;
        logic        oe;
        host.read(w, oe);
        check("serial_out_oe", 24'h000001, 24'(oe));
        check("overrange", 24'h000000, 24'(w[17]));
        check("polarity", 24'(pol), 24'(w[16]));
        near("count", ticks - 24'h000001, ticks + 24'h000002, 24'(w[15:0]));
        check("serial_out_oe", 24'h000000, 24'(serial_out_oe));
        check("result_overflow", 24'h000000, 24'(result_overflow));
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        zero_cross_in = 1'b0;
        convert_en_n = 1'b0;
        num_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_power_up();
        t_force_load();
        t_bare_pulse();
        t_convert(1'b0, 24'd100);
        t_read(1'b0, 24'd100);
        t_read(1'b0, 24'd100);
        t_convert(1'b1, 24'd50);
        t_read(1'b1, 24'd50);
        end_of_test();
    end
    initial begin
        repeat (50000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
endmodule
bind adc_sequencer adc_seq_sva chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .osc_output(osc_output),
    .zero_cross_in(zero_cross_in), .convert_en_n(convert_en_n), .load_n(load_n), .read_n(read_n),
    .serial_out_oe(serial_out_oe), .phase_sel(phase_sel), .result_valid_n(result_valid_n));
